// ---- src/spwm_consts.svh ----
// register offsets, field positions, reset values and counts
`ifndef SPWM_CONSTS_SVH
`define SPWM_CONSTS_SVH

`define SPWM_ADR_CTRL    8'h00
`define SPWM_ADR_DBUF    8'h04
`define SPWM_ADR_ACTIVE  8'h08
`define SPWM_ADR_LIMIT   8'h0c
`define SPWM_ADR_COUNT   8'h10
`define SPWM_ADR_TCTRL   8'h14
`define SPWM_ADR_FLAG    8'h18
`define SPWM_ADR_DIR     8'h1c
`define SPWM_ADR_ALIGN   2'h0

`define SPWM_RST_LIMIT   8'hff
`define SPWM_RST_DIR     1'b1
`define SPWM_RST_CTRL    6'h00

`define SPWM_MODE_LSB    0
`define SPWM_MODE_MSB    3
`define SPWM_MODE_HI_LSB 2
`define SPWM_MODE_PWM    2'h3
`define SPWM_MODE_OFF    4'h0
`define SPWM_DLOW_LSB    4
`define SPWM_DLOW_MSB    5
`define SPWM_CTRL_MSB    5

`define SPWM_PRE_LSB     0
`define SPWM_PRE_MSB     1
`define SPWM_RUN_BIT     2
`define SPWM_FLAG_BIT    1
`define SPWM_DIR_BIT     0
`define SPWM_SEL_LANE    0

`define SPWM_PHASE_LAST  2'h3
`define SPWM_PRE_LAST4   6'h03
`define SPWM_PRE_LAST16  6'h0f
`define SPWM_PRE_LAST64  6'h3f

`endif

// ---- src/spwm_pkg.sv ----
// types shared by the pwm unit and its timer
package spwm_pkg;

  typedef logic [7:0] spwm_byte_t;
  typedef logic [9:0] spwm_duty_t;

  typedef enum logic [1:0] {
    SPWM_PRE_1  = 2'h0,
    SPWM_PRE_4  = 2'h1,
    SPWM_PRE_16 = 2'h2,
    SPWM_PRE_64 = 2'h3
  } spwm_presc_t;

endpackage

// ---- src/spwm_tb_if.sv ----
// link between the pwm unit and its period timer
`timescale 1ns/1ps
interface spwm_tb_if;
  import spwm_pkg::*;

  logic        run;
  logic        sleep;
  spwm_presc_t presc;
  spwm_byte_t  limit;
  logic        cnt_we;
  spwm_byte_t  cnt_wdata;
  spwm_byte_t  count;
  logic [1:0]  low2;
  logic        tick;
  logic        boundary;

  modport timer (
    input  run, sleep, presc, limit, cnt_we, cnt_wdata,
    output count, low2, tick, boundary
  );
  modport ctrl (
    output run, sleep, presc, limit, cnt_we, cnt_wdata,
    input  count, low2, tick, boundary
  );
endinterface

// ---- src/spwm_timebase.sv ----
// period timer: clock phase, prescaler, period counter, time base
`timescale 1ns/1ps
`include "spwm_consts.svh"
module spwm_timebase
  import spwm_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  spwm_tb_if.timer tb
);

  logic [1:0] phase_q;
  logic [5:0] pre_q;
  spwm_byte_t cnt_q;
  logic [5:0] pre_last;
  logic       q_end;

  // ----------------------------------------------------------
  // prescale decode
  // ----------------------------------------------------------
  always_comb begin
    unique case (tb.presc)
      SPWM_PRE_1:  pre_last = '0;
      SPWM_PRE_4:  pre_last = `SPWM_PRE_LAST4;
      SPWM_PRE_16: pre_last = `SPWM_PRE_LAST16;
      SPWM_PRE_64: pre_last = `SPWM_PRE_LAST64;
    endcase
  end

  // one tick every four clocks times the prescale
  assign q_end = !tb.sleep && (phase_q == `SPWM_PHASE_LAST);
  // at or past the last step, so a smaller prescale never stalls the timer
  assign tb.tick = q_end && tb.run && (pre_q >= pre_last);
  assign tb.boundary = tb.tick && (cnt_q == tb.limit);
  assign tb.count = cnt_q;

  // low time base bits: clock phase at 1:1, else prescaler
  always_comb begin
    unique case (tb.presc)
      SPWM_PRE_1:  tb.low2 = phase_q;
      SPWM_PRE_4:  tb.low2 = pre_q[1:0];
      SPWM_PRE_16: tb.low2 = pre_q[3:2];
      SPWM_PRE_64: tb.low2 = pre_q[5:4];
    endcase
  end

  // ----------------------------------------------------------
  // counters
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= '0;
    end else if (!tb.sleep) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= '0;
    end else if (q_end && tb.run) begin
      pre_q <= tb.tick ? '0 : pre_q + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (tb.cnt_we) begin
      cnt_q <= tb.cnt_wdata;
    end else if (tb.boundary) begin
      cnt_q <= '0;
    end else if (tb.tick) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  sleep_freeze_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    tb.sleep && !tb.cnt_we |=> cnt_q == $past(cnt_q))
    else $error("period counter moved during sleep");

  tick_phase_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    tb.tick |-> phase_q == `SPWM_PHASE_LAST && !tb.sleep)
    else $error("timer tick off the fourth clock phase");

  tick_space_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    tb.tick |=> !tb.tick [*3])
    else $error("timer ticks closer than four clocks");

endmodule // spwm_timebase

// ---- src/spwm_top.sv ----
// standard pwm unit with period timer and wishbone registers
//
// Summary of operation
// - in pwm mode drive a modulated waveform with up to 10 bit duty
// - pin driven only while its direction bit selects output
// - writing zero to unit control releases the pin
// - period is (limit + 1) * 4 clocks * timer prescale
// - counter equal to limit clears on the next increment
// - at period start pin goes high unless the duty is zero
// - duty buffer byte copies into active duty at period start
// - timer postscaler plays no part in the pwm period
// - duty is buffer byte on top, control bits 5:4 below
// - duty buffer and low bits writable anytime, period unharmed
// - active duty and 2 bit latch double buffer the duty
// - active duty is read only while in pwm mode
// - time base is counter plus phase or prescaler bits
// - time base equal to duty drives the pin low
// - resolution is log2 of 4 * (limit + 1) bits
// - duty beyond the period leaves the pin unchanged
// - sleep freezes counter, unit state and pin level
// - mode field 11xx selects pwm, 0000 turns unit off
// - reset returns pin to input and registers to defaults
`timescale 1ns/1ps
`include "spwm_consts.svh"
module spwm_top
  import spwm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  input  wire logic        sleep,
  output logic             pwm_pin_out,
  output logic             pwm_pin_oe
);

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  logic [5:0]  ctrl_q;
  spwm_byte_t  dbuf_q;
  spwm_byte_t  active_q;
  logic [1:0]  latch_q;
  spwm_byte_t  limit_q;
  spwm_presc_t presc_q;
  logic        run_q;
  logic        flag_q;
  logic        dir_q;
  logic        out_q;
  logic        bnd_q;
  logic        oe_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic [31:0] dat_d;

  logic        req;
  logic        wr;
  logic [7:0]  adr_w;
  logic [3:0]  mode;
  logic        pwm_mode;
  logic        unit_off;
  spwm_duty_t  duty_next;
  spwm_duty_t  duty_now;
  spwm_duty_t  time_base;
  logic        match;

  spwm_tb_if tb ();

  spwm_timebase u_timebase (
    .clk     (clk),
    .reset_n (reset_n),
    .tb      (tb.timer)
  );

  // ----------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------
  assign req   = wb_cyc && wb_stb && !ack_q;
  assign wr    = req && wb_we && wb_sel[`SPWM_SEL_LANE];
  assign adr_w = {wb_adr[7:2], `SPWM_ADR_ALIGN};

  // ----------------------------------------------------------
  // mode and duty decode
  // ----------------------------------------------------------
  assign mode = ctrl_q[`SPWM_MODE_MSB:`SPWM_MODE_LSB];
  // pwm for any 11xx code
  assign pwm_mode = mode[`SPWM_MODE_MSB:`SPWM_MODE_HI_LSB]
                    == `SPWM_MODE_PWM;
  assign unit_off = mode == `SPWM_MODE_OFF;
  // 10 bit duty: buffer byte over low bits
  assign duty_next = {dbuf_q,
                      ctrl_q[`SPWM_DLOW_MSB:`SPWM_DLOW_LSB]};
  assign duty_now  = {active_q, latch_q};
  assign time_base = {tb.count, tb.low2};
  // no match ever occurs when duty lies past the period
  assign match = time_base == duty_now;

  // ----------------------------------------------------------
  // timer hookup, postscaler not modelled
  // ----------------------------------------------------------
  assign tb.run       = run_q;
  assign tb.sleep     = sleep;
  assign tb.presc     = presc_q;
  assign tb.limit     = limit_q;
  assign tb.cnt_we    = wr && adr_w == `SPWM_ADR_COUNT;
  assign tb.cnt_wdata = wb_dat_w[7:0];

  // ----------------------------------------------------------
  // software registers
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `SPWM_RST_CTRL;
    end else if (wr && adr_w == `SPWM_ADR_CTRL) begin
      ctrl_q <= wb_dat_w[`SPWM_CTRL_MSB:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dbuf_q <= '0;
    end else if (wr && adr_w == `SPWM_ADR_DBUF) begin
      dbuf_q <= wb_dat_w[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      limit_q <= `SPWM_RST_LIMIT;
    end else if (wr && adr_w == `SPWM_ADR_LIMIT) begin
      limit_q <= wb_dat_w[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      presc_q <= SPWM_PRE_1;
      run_q   <= 1'b0;
    end else if (wr && adr_w == `SPWM_ADR_TCTRL) begin
      presc_q <= spwm_presc_t'(wb_dat_w[`SPWM_PRE_MSB:`SPWM_PRE_LSB]);
      run_q   <= wb_dat_w[`SPWM_RUN_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dir_q <= `SPWM_RST_DIR;
    end else if (wr && adr_w == `SPWM_ADR_DIR) begin
      dir_q <= wb_dat_w[`SPWM_DIR_BIT];
    end
  end

  // timer match flag: write one clears, a new match wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= 1'b0;
    end else if (tb.boundary) begin
      flag_q <= 1'b1;
    end else if (wr && adr_w == `SPWM_ADR_FLAG
                 && wb_dat_w[`SPWM_FLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // duty double buffer
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      active_q <= '0;
      latch_q  <= '0;
    end else if (unit_off) begin
      active_q <= '0;
      latch_q  <= '0;
    end else if (pwm_mode && tb.boundary) begin
      // byte and low bits move together at period start
      active_q <= dbuf_q;
      latch_q  <= ctrl_q[`SPWM_DLOW_MSB:`SPWM_DLOW_LSB];
    end else if (!pwm_mode && wr && adr_w == `SPWM_ADR_ACTIVE) begin
      active_q <= wb_dat_w[7:0];
    end
  end

  // ----------------------------------------------------------
  // output latch and pin driver
  // ----------------------------------------------------------
  // period start, held while asleep so the set is not lost
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bnd_q <= 1'b0;
    end else if (!sleep) begin
      bnd_q <= tb.boundary;
    end
  end

  // set one clock after the boundary: the match clears one clock late,
  // so the high time is exactly duty steps of the time base
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_q <= 1'b0;
    end else if (!pwm_mode) begin
      out_q <= 1'b0;
    end else if (bnd_q && !sleep) begin
      out_q <= duty_now != '0;
    end else if (match && !sleep) begin
      out_q <= 1'b0;
    end
  end

  // the pin belongs to the unit only in pwm mode with output set
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= pwm_mode && !dir_q;
    end
  end

  assign pwm_pin_out = out_q;
  assign pwm_pin_oe  = oe_q;

  // ----------------------------------------------------------
  // read mux and acknowledge
  // ----------------------------------------------------------
  always_comb begin
    dat_d = '0;
    unique case (adr_w)
      `SPWM_ADR_CTRL:   dat_d[`SPWM_CTRL_MSB:0] = ctrl_q;
      `SPWM_ADR_DBUF:   dat_d[7:0] = dbuf_q;
      `SPWM_ADR_ACTIVE: dat_d[7:0] = active_q;
      `SPWM_ADR_LIMIT:  dat_d[7:0] = limit_q;
      `SPWM_ADR_COUNT:  dat_d[7:0] = tb.count;
      `SPWM_ADR_TCTRL: begin
        dat_d[`SPWM_PRE_MSB:`SPWM_PRE_LSB] = presc_q;
        dat_d[`SPWM_RUN_BIT] = run_q;
      end
      `SPWM_ADR_FLAG:   dat_d[`SPWM_FLAG_BIT] = flag_q;
      `SPWM_ADR_DIR:    dat_d[`SPWM_DIR_BIT] = dir_q;
      default:          dat_d = '0;
    endcase
  end

  // one wait-free answer per request, unmapped reads give zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= req;
      if (req && !wb_we) begin
        dat_q <= dat_d;
      end
    end
  end

  assign wb_ack   = ack_q;
  assign wb_dat_r = dat_q;

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  pin_dir_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    dir_q |=> !oe_q)
    else $error("pin driven while direction is input");

  ctrl_zero_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr && adr_w == `SPWM_ADR_CTRL && wb_dat_w[7:0] == 8'h00
    |-> ##2 !oe_q && !out_q)
    else $error("pin kept after control cleared");

  period_start_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    pwm_mode && bnd_q && !sleep && duty_now != '0 |=> out_q)
    else $error("pin not set at period start");

  zero_duty_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    pwm_mode && bnd_q && !sleep && duty_now == '0 |=> !out_q)
    else $error("pin set with zero duty");

  duty_latch_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    pwm_mode && !unit_off && tb.boundary
    |=> duty_now == $past(duty_next))
    else $error("duty not latched at period start");

  duty_hold_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    pwm_mode && !tb.boundary |=> $stable(duty_now))
    else $error("active duty moved mid period");

  active_ro_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    pwm_mode && wr && adr_w == `SPWM_ADR_ACTIVE && !tb.boundary
    |=> active_q == $past(active_q))
    else $error("active duty written in pwm mode");

  match_clear_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    pwm_mode && match && !bnd_q && !sleep |=> !out_q)
    else $error("pin not cleared on duty match");

  sleep_hold_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    sleep && pwm_mode && !wr |=> $stable(out_q))
    else $error("pin level changed during sleep");

  flag_set_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    tb.boundary && !tb.cnt_we |=> tb.count == 8'h00 && flag_q)
    else $error("period boundary did not restart");

  mode_off_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    unit_off |=> duty_now == '0 && !out_q)
    else $error("unit off did not clear duty and pin");

  oe_mode_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    !pwm_mode |=> !oe_q)
    else $error("pin driven outside pwm mode");

  oe_follow_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    pwm_mode && !dir_q |=> oe_q)
    else $error("pin not driven with direction set to output");

  low_latch_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    pwm_mode && tb.boundary
    |=> latch_q == $past(ctrl_q[`SPWM_DLOW_MSB:`SPWM_DLOW_LSB]))
    else $error("duty low bits not latched with the byte");

  dbuf_write_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr && adr_w == `SPWM_ADR_DBUF |=> dbuf_q == $past(wb_dat_w[7:0]))
    else $error("duty buffer write lost");

  beyond_period_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    pwm_mode && out_q && tb.count <= limit_q
    && duty_now > {limit_q, `SPWM_PHASE_LAST} |=> out_q)
    else $error("pin cleared by a duty past the period");

endmodule // spwm_top

// ---- verification/spwm_load.sv ----
// external load model that measures the waveform on the pwm pin
`timescale 1ns/1ps
module spwm_load (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        pin_out,
  input  wire logic        pin_oe,
  output logic             level,
  output logic      [15:0] hi_len,
  output logic      [15:0] per_len,
  output logic      [15:0] edges
);
  logic        level_q;
  logic [15:0] hi_q;
  logic [15:0] per_q;

  // a released pin is pulled down by the load
  assign level = pin_oe ? pin_out : 1'b0;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= 1'b0;
      hi_q    <= 16'h0000;
      per_q   <= 16'h0000;
      hi_len  <= 16'h0000;
      per_len <= 16'h0000;
      edges   <= 16'h0000;
    end else begin
      level_q <= level;
      if (level != level_q) begin
        edges <= edges + 16'h0001;
      end
      if (level && !level_q) begin
        hi_len  <= hi_q;
        per_len <= per_q;
        hi_q    <= 16'h0001;
        per_q   <= 16'h0001;
      end else begin
        hi_q  <= hi_q + {15'h0000, level};
        per_q <= per_q + 16'h0001;
      end
    end
  end
endmodule // spwm_load

// ---- verification/spwm_top_tb.sv ----
// self-checking bench for the pwm unit
`timescale 1ns/1ps
`include "spwm_consts.svh"
module spwm_top_tb;
  import spwm_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic        sleep;
  logic        pwm_pin_out;
  logic        pwm_pin_oe;
  logic        level;
  logic [15:0] hi_len;
  logic [15:0] per_len;
  logic [15:0] edges;
  logic [31:0] rd;
  logic [15:0] e0;
  int          bad_count;
  int          checked;
  int          cycles;

  spwm_top spwm_top_i (.clk(clk), .reset_n(reset_n), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .sleep(sleep), .pwm_pin_out(pwm_pin_out), .pwm_pin_oe(pwm_pin_oe));
  spwm_load spwm_load_i (.clk(clk), .reset_n(reset_n),
    .pin_out(pwm_pin_out), .pin_oe(pwm_pin_oe), .level(level),
    .hi_len(hi_len), .per_len(per_len), .edges(edges));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic close_out();
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      bad_count = bad_count + 1;
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // classic wishbone single cycle
  // ----------------------------------------------------------------
  task automatic wb_io(input logic [7:0] a, input logic w,
                       input logic [7:0] d, output logic [31:0] r);
    @(posedge clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= w;
    wb_adr   <= a;
    wb_dat_w <= {24'h000000, d};
    @(posedge clk);
    while (wb_ack !== 1'b1) @(posedge clk);
    r = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb_io(a, 1'b1, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb_io(a, 1'b0, 8'h00, rd);
    check(rd, exp);
  endtask

  // after two periods to settle, pin must hold one level with no edges
  task automatic steady(input logic lv);
    repeat (32) @(posedge clk);
    e0 = edges;
    repeat (80) @(posedge clk);
    check({31'h0, level}, {31'h0, lv});
    check({16'h0, edges}, {16'h0, e0});
  endtask

  initial begin
    cycles = 0;
    bad_count = 0;
    checked = 0;
    reset_n = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'hf;
    wb_dat_w = 32'h0;
    sleep = 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(`SPWM_ADR_CTRL, 32'h0);
    rd_chk(`SPWM_ADR_LIMIT, 32'hff);
    rd_chk(`SPWM_ADR_DIR, 32'h1);
    rd_chk(`SPWM_ADR_ACTIVE, 32'h0);
    check({31'h0, pwm_pin_oe}, 32'h0);
    wr(8'h20, 8'h5a);
    rd_chk(8'h20, 32'h0);
    // setup order: pin off, limit, mode with low bits, duty, flag, timer
    wr(`SPWM_ADR_DIR, 8'h01);
    wr(`SPWM_ADR_LIMIT, 8'h03);
    wr(`SPWM_ADR_CTRL, 8'h1c);
    wr(`SPWM_ADR_DBUF, 8'h02);
    wr(`SPWM_ADR_FLAG, 8'h02);
    wr(`SPWM_ADR_TCTRL, 8'h04);
    rd = 32'h0;
    for (int i = 0; i < 20 && rd[1] !== 1'b1; i++) begin
      wb_io(`SPWM_ADR_FLAG, 1'b0, 8'h00, rd);
    end
    check(rd & 32'h2, 32'h2);
    wr(`SPWM_ADR_DIR, 8'h00);
    repeat (3) @(posedge clk);
    check({31'h0, pwm_pin_oe}, 32'h1);
    // every prescale, postscaler bits set: period and high time scale
    for (int p = 0; p < 4; p++) begin
      wr(`SPWM_ADR_TCTRL, {6'b001111, p[1:0]});
      repeat (64 << (2 * p)) @(posedge clk);
      check({16'h0, per_len}, 32'd16 << (2 * p));
      check({16'h0, hi_len}, 32'd9 << (2 * p));
    end
    wr(`SPWM_ADR_TCTRL, 8'h04);
    rd_chk(`SPWM_ADR_ACTIVE, 32'h2);
    wr(`SPWM_ADR_ACTIVE, 8'h55);
    rd_chk(`SPWM_ADR_ACTIVE, 32'h2);
    // byte and low bits change together at the next boundary
    wr(`SPWM_ADR_CTRL, 8'h2c);
    wr(`SPWM_ADR_DBUF, 8'h01);
    repeat (48) @(posedge clk);
    check({16'h0, per_len}, 32'd16);
    check({16'h0, hi_len}, 32'd6);
    rd_chk(`SPWM_ADR_ACTIVE, 32'h1);
    // sleep freezes the count and the pin
    sleep <= 1'b1;
    wb_io(`SPWM_ADR_COUNT, 1'b0, 8'h00, rd);
    e0 = edges;
    repeat (40) @(posedge clk);
    rd_chk(`SPWM_ADR_COUNT, rd);
    check({16'h0, edges}, {16'h0, e0});
    sleep <= 1'b0;
    repeat (40) @(posedge clk);
    check({16'h0, hi_len}, 32'd6);
    wr(`SPWM_ADR_CTRL, 8'h0c);
    wr(`SPWM_ADR_DBUF, 8'h00);
    steady(1'b0);
    wr(`SPWM_ADR_DBUF, 8'hff);
    steady(1'b1);
    wr(`SPWM_ADR_DBUF, 8'h02);
    for (int m = 12; m < 16; m++) begin
      wr(`SPWM_ADR_CTRL, m[7:0]);
      repeat (3) @(posedge clk);
      check({31'h0, pwm_pin_oe}, 32'h1);
    end
    wr(`SPWM_ADR_DIR, 8'h01);
    repeat (3) @(posedge clk);
    check({31'h0, pwm_pin_oe}, 32'h0);
    wr(`SPWM_ADR_DIR, 8'h00);
    wr(`SPWM_ADR_CTRL, 8'h08);
    repeat (3) @(posedge clk);
    check({31'h0, pwm_pin_oe}, 32'h0);
    wr(`SPWM_ADR_ACTIVE, 8'h33);
    rd_chk(`SPWM_ADR_ACTIVE, 32'h33);
    wr(`SPWM_ADR_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    check({31'h0, pwm_pin_oe}, 32'h0);
    rd_chk(`SPWM_ADR_ACTIVE, 32'h0);
    close_out();
  end
endmodule // spwm_top_tb
